// file: hw/vpa_consts.vh
`ifndef VPA_CONSTS_VH
`define VPA_CONSTS_VH

// Directly decoded I/O ports
`define VPA_PORT_MODE_SELECT 10'h3D8
`define VPA_PORT_COLOUR_SELECT 10'h3D9
`define VPA_PORT_INDEX 10'h3DA
`define VPA_PORT_DATA 10'h3DE

// Internal array indices
`define VPA_IDX_PALETTE_MASK 8'h01
`define VPA_IDX_BORDER_COLOUR 8'h02
`define VPA_IDX_MODE_CONTROL 8'h03
`define VPA_IDX_PALETTE_BASE 4'h1

// Mode control field positions
`define VPA_MC_BORDER_EN 2
`define VPA_MC_HIRES4 3
`define VPA_MC_SIXTEEN 4

// Mode select (legacy) field positions
`define VPA_MS_HI_DOT 0
`define VPA_MS_GRAPHICS 1
`define VPA_MS_VIDEO_EN 3
`define VPA_MS_640 4
`define VPA_MS_BLINK_EN 5

// Colour select (legacy) field positions
`define VPA_CS_BG_INTENSITY 4

// Geometry
`define VPA_GLYPH_DOTS 3'h7
`define VPA_BANK_BYTES 13'h1F40

// Reset values
`define VPA_RST_INDEX 8'h00
`define VPA_RST_MASK 4'h0
`define VPA_RST_BORDER 4'h0
`define VPA_RST_MODE_CTRL 5'h00
`define VPA_RST_MODE_SEL 6'h00
`define VPA_RST_COLOUR_SEL 6'h00
`define VPA_RST_PALETTE 4'h0

`endif

// file: hw/vpa_fifo.v
`timescale 1ns/100ps
module vpa_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	assign in_ready = (count_q != DEPTH[AW:0]);
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage needs no reset; count gates every read
	always @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
			end
			if (push & ~pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop & ~push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule

// file: hw/vpa_array.v
`timescale 1ns/100ps
`include "vpa_consts.vh"

// How it works
// - Text cells use even byte as glyph code, odd byte as attribute.
// - Glyphs are 7x7 dots inside an 8-wide, 8 or 9 line cell.
// - Attribute: bits 3..0 foreground IRGB, 6..4 background RGB, 7 blink.
// - Graphics memory is two or four banks of 8000; top-left at 0000.
// - 640 four-colour and 320 sixteen-colour modes use four banks.
// - 640 two-colour, 320 four-colour, 160 sixteen-colour use two banks.
// - Two-colour mode: one bit per pixel, bit 7 shown first.
// - High four-colour: even byte gives bit 0, odd byte bit 1.
// - Medium sixteen-colour packs nibbles exactly like low-resolution mode.
// - Sixteen-colour: bits 7..4 first pixel, bits 3..0 second.
// - Medium four-colour: four 2-bit pixels, bits 7..6 first.
// - Host writes index port, then data goes to indexed register.
// - Legacy mode and colour select registers decode at own addresses.
// - Index 01 mask, 02 border, 03 mode control, 10-1F palette.
// - Each set mask bit forces matching palette address line to zero.
// - Border register bits: blue, green, red, intensity.
// - Mode control is 5 bits; bits 0 and 1 have no effect.
// - Mode bit 2 enables border, bit 3 high 4-colour, bit 4 16-colour.
// - Palette is sixteen 4-bit entries, blue bit 0 to intensity bit 3.
module vpa_array #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Host I/O write port
	input wire io_wr,
	input wire [9:0] io_addr,
	input wire [7:0] io_wdata,
	// Video memory word stream, even byte in [7:0]
	input wire mem_valid,
	output wire mem_ready,
	input wire [15:0] mem_data,
	// Fetch address toward video memory
	output wire [1:0] fetch_bank,
	output wire [12:0] fetch_offset,
	// Timing from the CRT controller
	input wire frame_start,
	input wire line_start,
	input wire display_en,
	input wire blink_phase,
	input wire [3:0] scan_row,
	// Glyph ROM
	output wire [7:0] glyph_code,
	output wire [3:0] glyph_row,
	input wire [7:0] glyph_bits,
	// Pixel output
	output wire pix_valid,
	output wire colour_index_bit0,
	output wire colour_index_bit1,
	output wire colour_index_bit2,
	output wire colour_index_bit3,
	output wire [3:0] four_bit_colour_output
);
	localparam ST_IDLE = 3'b001;
	localparam ST_GLYPH = 3'b010;
	localparam ST_SHIFT = 3'b100;

	reg [7:0] index_q;
	reg [3:0] mask_q;
	reg [3:0] border_q;
	reg [4:0] mode_ctrl_q;
	reg [5:0] mode_sel_q;
	reg [5:0] colour_sel_q;
	wire [3:0] pal_w [0:15];
	wire data_wr;

	// Host port decode
	assign data_wr = io_wr & (io_addr == `VPA_PORT_DATA);

	always @(posedge core_clk) begin
		if (rst) begin
			index_q <= `VPA_RST_INDEX;
			mask_q <= `VPA_RST_MASK;
			border_q <= `VPA_RST_BORDER;
			mode_ctrl_q <= `VPA_RST_MODE_CTRL;
			mode_sel_q <= `VPA_RST_MODE_SEL;
			colour_sel_q <= `VPA_RST_COLOUR_SEL;
		end else if (io_wr) begin
			if (io_addr == `VPA_PORT_INDEX) begin
				index_q <= io_wdata;
			end
			if (io_addr == `VPA_PORT_MODE_SELECT) begin
				mode_sel_q <= io_wdata[5:0];
			end
			if (io_addr == `VPA_PORT_COLOUR_SELECT) begin
				colour_sel_q <= io_wdata[5:0];
			end
			if (data_wr && index_q == `VPA_IDX_PALETTE_MASK) begin
				mask_q <= io_wdata[3:0];
			end
			if (data_wr && index_q == `VPA_IDX_BORDER_COLOUR) begin
				border_q <= io_wdata[3:0];
			end
			if (data_wr && index_q == `VPA_IDX_MODE_CONTROL) begin
				mode_ctrl_q <= io_wdata[4:0];
			end
		end
	end

	// Palette entries, one register each
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_pal
			reg [3:0] entry_q;
			always @(posedge core_clk) begin
				if (rst) begin
					entry_q <= `VPA_RST_PALETTE;
				end else if (data_wr && index_q == {`VPA_IDX_PALETTE_BASE, gi[3:0]}) begin
					entry_q <= io_wdata[3:0];
				end
			end
			assign pal_w[gi] = entry_q;
		end
	endgenerate

	// Mode decode; mode control bits 0 and 1 are never read
	wire graphics = mode_sel_q[`VPA_MS_GRAPHICS];
	wire sixteen = mode_ctrl_q[`VPA_MC_SIXTEEN];
	wire hires4 = mode_ctrl_q[`VPA_MC_HIRES4];
	wire two_col = graphics & ~sixteen & ~hires4 & mode_sel_q[`VPA_MS_640];
	wire blink_en = mode_sel_q[`VPA_MS_BLINK_EN];
	wire four_banks = graphics & (hires4 | (sixteen & mode_sel_q[`VPA_MS_HI_DOT]));

	// Bank interleave address generator
	reg [1:0] bank_q;
	reg [12:0] offset_q;
	reg [12:0] line_base_q;
	wire [1:0] bank_next;
	wire word_pop;

	assign bank_next = four_banks ? bank_q + 2'h1 : {1'b0, ~bank_q[0]};
	assign fetch_bank = bank_q;
	assign fetch_offset = offset_q;

	always @(posedge core_clk) begin
		if (rst || frame_start) begin
			bank_q <= 2'h0;
			offset_q <= 13'h0000;
			line_base_q <= 13'h0000;
		end else if (line_start) begin
			bank_q <= bank_next;
			// A full bank cycle moves on; otherwise the same bytes come from the next bank
			if (bank_next == 2'h0) begin
				line_base_q <= offset_q;
			end else begin
				offset_q <= line_base_q;
			end
		end else if (word_pop && graphics) begin
			offset_q <= (offset_q >= `VPA_BANK_BYTES - 13'h2) ? 13'h0000 : offset_q + 13'h2;
		end
	end

	// Word buffer between memory and pixel engine
	wire fifo_valid;
	wire [15:0] fifo_data;
	reg [2:0] state_q;

	assign word_pop = fifo_valid & (state_q == ST_IDLE);

	vpa_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(mem_valid),
		.in_ready(mem_ready),
		.in_data(mem_data),
		.out_valid(fifo_valid),
		.out_ready(state_q == ST_IDLE),
		.out_data(fifo_data)
	);

	// Graphics bytes rearranged so each pixel sits at the top of the shifter
	reg [15:0] seq;
	integer k;
	always @* begin
		seq = {fifo_data[7:0], fifo_data[15:8]};
		if (hires4) begin
			for (k = 0; k < 8; k = k + 1) begin
				seq[2 * k + 1] = fifo_data[8 + k];
				seq[2 * k] = fifo_data[k];
			end
		end
	end

	// Pixel engine
	reg [15:0] shift_q;
	reg [4:0] cnt_q;
	reg [7:0] glyph_code_q;
	reg [3:0] glyph_row_q;
	reg [7:0] attr_q;
	reg text_q;
	wire [4:0] px_per_word;
	wire [15:0] glyph_masked;

	assign px_per_word = sixteen ? 5'd4 : (two_col ? 5'd16 : 5'd8);
	assign glyph_code = glyph_code_q;
	assign glyph_row = glyph_row_q;
	// Eighth dot column and rows past the seventh are always blank
	assign glyph_masked = (glyph_row_q < {1'b0, `VPA_GLYPH_DOTS}) ?
		{glyph_bits[7:1], 9'h000} : 16'h0000;

	always @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			shift_q <= 16'h0000;
			cnt_q <= 5'h00;
			glyph_code_q <= 8'h00;
			glyph_row_q <= 4'h0;
			attr_q <= 8'h00;
			text_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (fifo_valid) begin
						text_q <= ~graphics;
						if (graphics) begin
							shift_q <= seq;
							cnt_q <= px_per_word;
							state_q <= ST_SHIFT;
						end else begin
							glyph_code_q <= fifo_data[7:0];
							attr_q <= fifo_data[15:8];
							glyph_row_q <= scan_row;
							state_q <= ST_GLYPH;
						end
					end
				end
				ST_GLYPH: begin
					shift_q <= glyph_masked;
					cnt_q <= 5'd8;
					state_q <= ST_SHIFT;
				end
				ST_SHIFT: begin
					if (text_q || two_col) begin
						shift_q <= {shift_q[14:0], 1'b0};
					end else if (sixteen) begin
						shift_q <= {shift_q[11:0], 4'h0};
					end else begin
						shift_q <= {shift_q[13:0], 2'h0};
					end
					cnt_q <= cnt_q - 5'h01;
					if (cnt_q == 5'h01) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Raw palette address of the pixel now at the top of the shifter
	reg [3:0] raw_px;
	always @* begin
		if (text_q) begin
			if (shift_q[15] && !(blink_en && attr_q[7] && blink_phase)) begin
				raw_px = attr_q[3:0];
			end else if (blink_en) begin
				raw_px = {colour_sel_q[`VPA_CS_BG_INTENSITY], attr_q[6:4]};
			end else begin
				raw_px = attr_q[7:4];
			end
		end else if (sixteen) begin
			raw_px = shift_q[15:12];
		end else if (two_col) begin
			raw_px = {colour_sel_q[3:1], shift_q[15]};
		end else begin
			raw_px = {colour_sel_q[3:2], shift_q[15:14]};
		end
	end

	// Output pipeline: mask stage, then palette and border stage
	reg st1_valid_q;
	reg [3:0] st1_idx_q;
	reg st2_valid_q;
	reg [3:0] colour_q;
	wire [3:0] border_colour;

	assign border_colour = mode_ctrl_q[`VPA_MC_BORDER_EN] ? border_q : colour_sel_q[3:0];

	always @(posedge core_clk) begin
		if (rst) begin
			st1_valid_q <= 1'b0;
			st1_idx_q <= 4'h0;
			st2_valid_q <= 1'b0;
			colour_q <= 4'h0;
		end else begin
			st1_valid_q <= (state_q == ST_SHIFT);
			st1_idx_q <= raw_px & ~mask_q;
			st2_valid_q <= st1_valid_q;
			if (!mode_sel_q[`VPA_MS_VIDEO_EN]) begin
				colour_q <= 4'h0;
			end else if (st1_valid_q) begin
				colour_q <= pal_w[st1_idx_q];
			end else if (!display_en) begin
				colour_q <= border_colour;
			end else begin
				colour_q <= 4'h0;
			end
		end
	end

	assign colour_index_bit0 = st1_idx_q[0];
	assign colour_index_bit1 = st1_idx_q[1];
	assign colour_index_bit2 = st1_idx_q[2];
	assign colour_index_bit3 = st1_idx_q[3];
	assign pix_valid = st2_valid_q;
	assign four_bit_colour_output = colour_q;
endmodule

// file: tb/vpa_array_properties.sv
`timescale 1ns/100ps
module vpa_array_properties (
	// Clock and reset
	input logic core_clk,
	input logic rst,
	// Host writes
	input logic io_wr,
	input logic [9:0] io_addr,
	input logic [7:0] io_wdata,
	// Fetch timing
	input logic frame_start,
	input logic line_start,
	input logic [1:0] fetch_bank,
	input logic [12:0] fetch_offset,
	// Pixels
	input logic pix_valid,
	input logic colour_index_bit0,
	input logic colour_index_bit1,
	input logic colour_index_bit2,
	input logic colour_index_bit3,
	input logic [3:0] four_bit_colour_output
);
	logic [7:0] idx_q;
	logic [3:0] mask_q;
	logic [4:0] mc_q;
	logic [5:0] ms_q;
	logic [4:0] run_q;
	logic [3:0] pal_q [16];
	logic [3:0] ci;
	logic four;
	logic [4:0] n_px;
	assign ci = {colour_index_bit3, colour_index_bit2, colour_index_bit1, colour_index_bit0};
	assign four = mc_q[3] | (mc_q[4] & ms_q[0]);
	assign n_px = mc_q[4] ? 5'h04 : (ms_q[1] & ms_q[4] & !mc_q[3]) ? 5'h10 : 5'h08;
	// Shadow of host state; palette left unreset, bench loads it before any pixel
	always @(posedge core_clk) begin
		if (rst) begin
			idx_q <= 8'h00;
			mask_q <= 4'h0;
			mc_q <= 5'h00;
			ms_q <= 6'h00;
			run_q <= 5'h00;
		end else begin
			run_q <= pix_valid ? run_q + 5'h01 : 5'h00;
			if (io_wr && io_addr == 10'h3D8)
				ms_q <= io_wdata[5:0];
			if (io_wr && io_addr == 10'h3DA)
				idx_q <= io_wdata;
			if (io_wr && io_addr == 10'h3DE && idx_q == 8'h01)
				mask_q <= io_wdata[3:0];
			if (io_wr && io_addr == 10'h3DE && idx_q == 8'h03)
				mc_q <= io_wdata[4:0];
		end
		if (!rst && io_wr && io_addr == 10'h3DE && idx_q[7:4] == 4'h1)
			pal_q[idx_q[3:0]] <= io_wdata[3:0];
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_step1;
		line_start && !frame_start && fetch_bank == 2'h1;
	endsequence
	sequence s_run_end;
		$fell(pix_valid);
	endsequence
	AST_FRAME_HOME: assert property (frame_start |=> fetch_bank == 2'h0 && fetch_offset == 13'h0)
		else $error("fetch not homed");
	AST_OFFSET_RANGE: assert property (fetch_offset < 13'h1F40 && !fetch_offset[0])
		else $error("fetch offset out of bank");
	AST_BANK_TWO: assert property (s_step1 ##0 !four |=> fetch_bank == 2'h0)
		else $error("two-bank step wrong");
	AST_BANK_FOUR: assert property (s_step1 ##0 four |=> fetch_bank == 2'h2)
		else $error("four-bank step wrong");
	AST_RUN_LEN: assert property (s_run_end |-> run_q == n_px)
		else $error("pixels per word wrong");
	AST_RUN_MAX: assert property (run_q <= 5'h10)
		else $error("pixel run too long");
	AST_MASK: assert property (pix_valid |-> ($past(ci) & mask_q) == 4'h0)
		else $error("masked line not zero");
	AST_PAL_LOOK: assert property (pix_valid |-> four_bit_colour_output == pal_q[$past(ci)])
		else $error("palette lookup wrong");
endmodule
bind vpa_array vpa_array_properties u_vpa_array_properties (.core_clk, .rst, .io_wr,
	.io_addr, .io_wdata, .frame_start, .line_start, .fetch_bank, .fetch_offset, .pix_valid,
	.colour_index_bit0, .colour_index_bit1, .colour_index_bit2, .colour_index_bit3,
	.four_bit_colour_output);

// file: tb/vpa_glyph_rom.sv
`timescale 1ns/100ps
module vpa_glyph_rom (
	// Lookup
	input logic [7:0] glyph_code,
	input logic [3:0] glyph_row,
	// Row data
	output logic [7:0] glyph_bits
);
	// Depends on row too, so a wrong row shows up
	assign glyph_bits = glyph_code ^ {glyph_row, glyph_row};
endmodule

// file: tb/video_pixel_format_array_tb_top.sv
`timescale 1ns/100ps
module video_pixel_format_array_tb_top;
	logic core_clk = 0;
	logic rst = 1;
	logic io_wr = 0;
	logic mem_valid = 0;
	logic frame_start = 0;
	logic line_start = 0;
	logic display_en = 1;
	logic blink_phase = 0;
	logic ready_low = 0;
	logic [9:0] io_addr = 0;
	logic [7:0] io_wdata = 0;
	logic [15:0] mem_data = 0;
	logic [3:0] scan_row = 4'h3;
	logic [3:0] key, mask, cs;
	logic [3:0] got [$];
	wire mem_ready, pix_valid;
	wire colour_index_bit0, colour_index_bit1, colour_index_bit2, colour_index_bit3;
	wire [1:0] fetch_bank;
	wire [12:0] fetch_offset;
	wire [7:0] glyph_code, glyph_bits;
	wire [3:0] glyph_row, four_bit_colour_output;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [7:0] ms_t [6] = '{8'h1B, 8'h0A, 8'h1B, 8'h0A, 8'h09, 8'h29};
	logic [4:0] mc_t [6] = '{5'h00, 5'h00, 5'h08, 5'h10, 5'h00, 5'h00};
	int np_t [6] = '{16, 8, 8, 4, 8, 8};
	vpa_array u_vpa_array (.core_clk, .rst, .io_wr, .io_addr, .io_wdata, .mem_valid,
		.mem_ready, .mem_data, .fetch_bank, .fetch_offset, .frame_start, .line_start,
		.display_en, .blink_phase, .scan_row, .glyph_code, .glyph_row, .glyph_bits,
		.pix_valid, .colour_index_bit0, .colour_index_bit1, .colour_index_bit2,
		.colour_index_bit3, .four_bit_colour_output);
	vpa_glyph_rom u_vpa_glyph_rom (.glyph_code, .glyph_row, .glyph_bits);
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (pix_valid === 1'b1)
			got.push_back(four_bit_colour_output);
		if (mem_ready === 1'b0)
			ready_low <= 1'b1;
	end
	task automatic end_of_test;
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1;
		@(posedge core_clk);
		#1;
	endtask
	// Leaves valid high so back-to-back words need no dead cycle
	task automatic push(input logic [15:0] w);
		int i;
		i = 0;
		mem_data = w;
		mem_valid = 1;
		// Ready is judged settled, before the edge that takes the word
		while (mem_ready !== 1'b1 && i < 200) begin
			@(posedge core_clk);
			#1;
			i++;
		end
		@(posedge core_clk);
		#1;
		if (i >= 200) begin
			error_cnt++;
			end_of_test();
		end
	endtask
	task automatic wait_cycles(input int n);
		io_wr = 0;
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	function automatic logic [3:0] expect_px(int m, logic [15:0] w, int i);
		logic [7:0] b;
		logic [7:0] g;
		logic [3:0] r;
		b = (i < ((m == 0) ? 8 : 4)) ? w[7:0] : w[15:8];
		g = w[7:0] ^ 8'h33;
		case (m)
			0: r = {cs[3:1], b[7 - i % 8]};
			1: r = {cs[3:2], b[7 - 2 * (i % 4) -: 2]};
			2: r = {cs[3:2], w[15 - i], w[7 - i]};
			3: r = w[((i < 2) ? 7 : 15) - 4 * (i % 2) -: 4];
			4: r = (i < 7 && g[7 - i]) ? w[11:8] : w[15:12];
			// Blink on with phase high: attr bit 7 hides the dot, background intensity from 3D9
			default: r = (i < 7 && g[7 - i] && !w[15]) ? w[11:8] : {1'b0, w[14:12]};
		endcase
		return (r & ~mask) ^ key;
	endfunction
	initial begin
		int m, k, j, t;
		logic [15:0] w [$];
		logic [7:0] b2;
		void'($urandom(79));
		repeat (2) @(posedge core_clk);
		#1;
		rst = 0;
		chk(four_bit_colour_output, 16'h0000);
		key = 4'($urandom);
		cs = 4'($urandom);
		wr(10'h3D9, {4'h0, cs});
		for (k = 0; k < 16; k++) begin
			wr(10'h3DA, 8'h10 + 8'(k));
			wr(10'h3DE, {4'h0, 4'(k) ^ key});
		end
		for (m = 0; m < 6; m++) begin
			mask = (m == 4) ? 4'h0 : 4'($urandom);
			blink_phase = (m == 5);
			wr(10'h3D8, ms_t[m]);
			wr(10'h3DA, 8'h03);
			wr(10'h3DE, {3'h0, mc_t[m]} | 8'($urandom % 4));
			wr(10'h3DA, 8'h01);
			wr(10'h3DE, {4'h0, mask});
			io_wr = 0;
			frame_start = 1;
			@(posedge core_clk);
			#1;
			frame_start = 0;
			line_start = 1;
			repeat (2) @(posedge core_clk);
			#1;
			line_start = 0;
			got.delete();
			w.delete();
			for (k = 0; k < 20; k++) begin
				w.push_back((k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : 16'($urandom));
				push(w[k]);
			end
			mem_valid = 0;
			t = 0;
			while (got.size() < 20 * np_t[m] && t < 2000) begin
				@(posedge core_clk);
				t++;
			end
			#1;
			if (t >= 2000) begin
				error_cnt++;
				end_of_test();
			end
			for (k = 0; k < 20; k++)
				for (j = 0; j < np_t[m]; j++)
					chk(got[k * np_t[m] + j], expect_px(m, w[k], j));
		end
		chk(ready_low, 1'b1);
		b2 = 8'($urandom);
		wr(10'h3DA, 8'h02);
		wr(10'h3DE, ~b2);
		wr(10'h3DE, b2);
		wr(10'h3DA, 8'h04);
		wr(10'h3DE, ~b2);
		wr(10'h3DA, 8'h03);
		wr(10'h3DE, 8'h04);
		display_en = 0;
		wait_cycles(4);
		chk(four_bit_colour_output, b2[3:0]);
		wr(10'h3DA, 8'h03);
		wr(10'h3DE, 8'h00);
		wait_cycles(4);
		chk(four_bit_colour_output, cs);
		end_of_test();
	end
endmodule
